// file: include/cpw_pkg.sv
// package: constants and types for the pwm unit
package cpw_pkg;
  localparam int unsigned DUTY_W = 10;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned PRE_W = 4;
  localparam int unsigned MODE_W = 4;
  localparam logic [7:0] PERIOD_LIMIT_RST = 8'hff;
  localparam logic [7:0] DUTY_HI_RST = 8'h00;
  localparam logic [7:0] DUTY_LO_RST = 8'h00;
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [1:0] PWM_MODE_TOP = 2'h3;
  localparam int unsigned LEFT_HI_POS = 2;
  localparam int unsigned LEFT_LO_POS = 6;
  localparam int unsigned RIGHT_HI_POS = 8;
  localparam int unsigned DIV_SYS = 4;
  localparam real MCLK_MHZ = 20.0;
  localparam int unsigned PRE_BITS_SHIFT = 2;
  typedef enum logic [2:0]
  {
    PRE_1 = 3'b000,
    PRE_2 = 3'b001,
    PRE_4 = 3'b010,
    PRE_8 = 3'b011,
    PRE_16 = 3'b100,
    PRE_32 = 3'b101,
    PRE_64 = 3'b110,
    PRE_128 = 3'b111
  } cpw_pre_t;
  typedef enum logic [0:0]
  {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } cpw_state_t;
endpackage

// file: include/cpw_tb_if.sv
// interface: time-base link between the prescaler and the compare core
`timescale 1ns/1ps
`default_nettype none
interface cpw_tb_if;
  logic tick;
  logic [1:0] low_bits;
  modport src (output tick, output low_bits);
  modport dst (input tick, input low_bits);
endinterface
`default_nettype wire

// file: src/cpw_prescale.sv
// module: system-clock phase and timer prescaler for the period counter
`timescale 1ns/1ps
`default_nettype none
module cpw_prescale
  import cpw_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_run,
  input wire cpw_pkg::cpw_pre_t i_pre,
  cpw_tb_if.src o_tb
);
  import cpw_pkg::*;
  typedef struct packed
  {
    logic [1:0] phase;
    logic [6:0] pre;
  } cpw_ps_t;
  cpw_ps_t r;
  cpw_ps_t next_r;
  logic [6:0] pre_max;
  logic [1:0] low2;
  always_comb
  begin
    pre_max = 7'((8'h01 << i_pre) - 8'h01);
    next_r = r;
    if (i_run)
    begin
      // system clock split into four phases: one instruction tick
      next_r.phase = r.phase + 2'h1;
      if (r.phase == 2'h3)
        next_r.pre = (r.pre >= pre_max) ? 7'h00 : r.pre + 7'h01;
    end
  end
  always_comb
  begin
    // low two bits: clock phase at 1:1, prescaler bit and top phase bit at 1:2, else top prescaler bits
    unique case (i_pre)
      PRE_1: low2 = r.phase;
      PRE_2: low2 = {r.pre[0], r.phase[1]};
      default: low2 = 2'(r.pre >> (i_pre - 3'h2));
    endcase
  end
  assign o_tb.low_bits = low2;
  assign o_tb.tick = i_run && r.phase == 2'h3 && r.pre >= pre_max;
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      r <= '0;
    else
      r <= next_r;
  end
endmodule
`default_nettype wire

// file: src/cpw_pwm.sv
// module: standard pwm unit with period counter and buffered duty value
`timescale 1ns/1ps
`default_nettype none
// How it works
// - compare needs running timer; sleep halts it
// - ten-bit pwm waveform on pin
// - rollover clears counter, sets pin unless duty is zero or beyond period, reloads
// - period is (limit+1)*4*tosc*prescale
// - postscaler does not affect period
// - duty write takes effect at rollover
// - width equals duty*tosc*prescale
// - time base: counter plus two bits
// - pin clears when time base matches
// - resolution log2 of 4*(limit+1)
// - duty beyond period leaves pin unchanged
// - sleep freezes counter and pin
// - frequency follows system clock
// - reset restores inputs and register defaults
// - alignment one: left-aligned duty
// - alignment zero: right-aligned duty
module cpw_pwm
  import cpw_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_unit_enable,
  input wire logic [3:0] i_unit_mode,
  input wire logic i_duty_alignment,
  input wire logic [7:0] i_duty_hi,
  input wire logic [7:0] i_duty_lo,
  input wire logic i_duty_wr,
  input wire logic [7:0] i_period_limit,
  input wire logic i_period_limit_wr,
  input wire logic i_timer_on,
  input wire cpw_pkg::cpw_pre_t i_timer_prescale_select,
  input wire logic i_sleep,
  input wire logic i_pin_direction,
  input wire logic i_period_match_flag_clr,
  output logic o_waveform_pin,
  output logic o_waveform_pin_oe_n,
  output logic o_unit_out,
  output logic [7:0] o_period_counter,
  output logic o_period_match_flag,
  output logic o_running
);
  import cpw_pkg::*;
  typedef struct packed
  {
    cpw_state_t st;
    logic [7:0] cnt;
    logic [7:0] limit;
    logic [7:0] dhi;
    logic [7:0] dlo;
    logic [9:0] duty_buf;
    logic out;
    logic flag;
  } cpw_st_t;
  cpw_st_t r;
  cpw_st_t next_r;
  cpw_tb_if tb ();
  logic pwm_mode;
  logic run;
  logic [9:0] duty_reg;
  logic [9:0] time_base;
  logic [9:0] span;

  // duty value unpacking by alignment
  function automatic logic [9:0] duty_of(input logic left, input logic [7:0] hi, input logic [7:0] lo);
    if (left)
      return {hi, lo[7:LEFT_LO_POS]};
    return {hi[1:0], lo};
  endfunction

  assign pwm_mode = i_unit_enable && i_unit_mode[3:2] == PWM_MODE_TOP;
  // sleep gates the whole time base, so counter, prescaler and compare hold
  // matching only advances while the timer runs
  assign run = i_timer_on && !i_sleep;
  assign duty_reg = duty_of(i_duty_alignment, r.dhi, r.dlo);
  assign time_base = {r.cnt, tb.low_bits};
  // one period spans 4*(limit+1) time-base steps
  assign span = {r.limit, 2'h3};

  // postscaler is deliberately absent from this path
  cpw_prescale u_pre
  (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_run(run),
    .i_pre(i_timer_prescale_select),
    .o_tb(tb)
  );

  always_comb
  begin
    next_r = r;
    if (i_period_limit_wr)
      next_r.limit = i_period_limit;
    if (i_duty_wr)
    begin
      // writes land in the holding pair only, never the live compare
      next_r.dhi = i_duty_hi;
      next_r.dlo = i_duty_lo;
    end
    if (i_period_match_flag_clr)
      next_r.flag = 1'b0;
    next_r.st = run ? ST_RUN : ST_IDLE;
    if (run && pwm_mode)
    begin
      // pin clears on match; a duty beyond the span never matches
      // width is duty time-base steps from rollover
      if (time_base == r.duty_buf && r.duty_buf <= span)
        next_r.out = 1'b0;
    end
    if (run && tb.tick)
    begin
      if (r.cnt == r.limit)
      begin
        next_r.cnt = 8'h00;
        next_r.flag = 1'b1; // set wins over clear
        if (pwm_mode)
        begin
          next_r.duty_buf = duty_reg;
          // zero duty keeps pin low; oversize duty holds level
          if (duty_reg == 10'h000)
            next_r.out = 1'b0;
          else if (duty_reg <= span)
            next_r.out = 1'b1;
        end
      end
      else
        next_r.cnt = r.cnt + 8'h01;
    end
    if (!i_unit_enable)
      next_r.out = 1'b0;
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      r.st <= ST_IDLE;
      r.cnt <= 8'h00;
      r.limit <= PERIOD_LIMIT_RST;
      r.dhi <= DUTY_HI_RST;
      r.dlo <= DUTY_LO_RST;
      r.duty_buf <= 10'h000;
      r.out <= 1'b0;
      r.flag <= 1'b0;
    end
    else
      r <= next_r;
  end

  assign o_waveform_pin = r.out;
  // driver follows pin direction in pwm mode only; reset leaves it as input
  assign o_waveform_pin_oe_n = !i_rst_n || i_pin_direction || !pwm_mode;
  assign o_unit_out = r.out;
  assign o_period_counter = r.cnt;
  assign o_period_match_flag = r.flag;
  assign o_running = r.st == ST_RUN;
endmodule
`default_nettype wire

// file: test/cpw_load.sv
// model: load on the pwm pin, measures high time and period
`timescale 1ns/1ps
`default_nettype none
module cpw_load
(
  input wire logic i_mclk,
  input wire logic i_level,
  output int o_high,
  output int o_period
);
  int h = 0;
  int p = 0;
  logic last = 0;
  // rise to rise is one full period
  always @(posedge i_mclk)
  begin
    last <= i_level;
    p <= p + 1;
    h <= h + (i_level ? 1 : 0);
    if (i_level && !last)
    begin
      o_high <= h;
      o_period <= p;
      h <= 1;
      p <= 1;
    end
  end
endmodule
`default_nettype wire

// file: test/cpw_pwm_properties.sv
// checker: port timing of the pwm unit
`timescale 1ns/1ps
`default_nettype none
module cpw_pwm_properties
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_unit_enable,
  input wire logic [3:0] i_unit_mode,
  input wire logic i_sleep,
  input wire logic i_pin_direction,
  input wire logic i_period_match_flag_clr,
  input wire logic o_waveform_pin,
  input wire logic o_waveform_pin_oe_n,
  input wire logic o_unit_out,
  input wire logic [7:0] o_period_counter,
  input wire logic o_period_match_flag
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence rollover;
    $rose(o_period_match_flag);
  endsequence
  sequence frozen;
    $stable(o_period_counter) && $stable(o_waveform_pin);
  endsequence
  chk_pin_drive_enable: assert property (o_waveform_pin_oe_n == (i_pin_direction || !i_unit_enable || i_unit_mode[3:2] != 2'b11))
    else $error("oe level wrong");
  chk_out_mirrors_pin: assert property (o_unit_out == o_waveform_pin)
    else $error("out bit differs");
  chk_disabled_pin_low: assert property (!i_unit_enable |=> !o_waveform_pin)
    else $error("pin high while off");
  chk_rollover_clears: assert property (rollover |-> o_period_counter == 8'h00)
    else $error("counter not cleared");
  chk_rise_at_rollover: assert property ($rose(o_waveform_pin) |-> o_period_counter == 8'h00 && o_period_match_flag)
    else $error("pin rose off rollover");
  chk_sleep_freezes: assert property (i_sleep [*2] |=> frozen)
    else $error("moved in sleep");
  chk_flag_sticky: assert property (o_period_match_flag && !i_period_match_flag_clr |=> o_period_match_flag)
    else $error("flag dropped");
  chk_pin_rise_flag: assert property (!o_waveform_pin ##1 o_waveform_pin |-> $rose(o_period_match_flag) || o_period_match_flag)
    else $error("rise without flag");
endmodule
bind cpw_pwm cpw_pwm_properties chk (.*);
`default_nettype wire

// file: test/testbench.sv
// testbench: directed pwm scenarios against a pin load
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cpw_pkg::*;
  logic i_mclk = 0, i_rst_n = 0, i_unit_enable = 0, i_duty_alignment = 0, i_duty_wr = 0, i_period_limit_wr = 0;
  logic i_timer_on = 0, i_sleep = 0, i_pin_direction = 1, i_period_match_flag_clr = 0;
  logic [3:0] i_unit_mode = 4'h0;
  logic [7:0] i_duty_hi = 8'h00, i_duty_lo = 8'h00, i_period_limit = 8'h00, held;
  cpw_pre_t i_timer_prescale_select = PRE_1;
  logic o_waveform_pin, o_waveform_pin_oe_n, o_unit_out, o_period_match_flag, o_running;
  logic [7:0] o_period_counter;
  int high, period, errors = 0, checked = 0;
  // one clock feeds both timers, and at 1:1 also the undivided compare path
  always #25 i_mclk = ~i_mclk;
  cpw_pwm dut (.*);
  // released pin falls to the pull-down
  cpw_load load (.i_mclk(i_mclk), .i_level(o_waveform_pin_oe_n ? 1'b0 : o_waveform_pin), .o_high(high), .o_period(period));
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #5;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic duty(input logic al, input logic [7:0] hi, input logic [7:0] lo, input cpw_pre_t pre);
    i_duty_alignment = al;
    i_duty_hi = hi;
    i_duty_lo = lo;
    i_timer_prescale_select = pre;
    i_duty_wr = 1;
    step(1);
    i_duty_wr = 0;
  endtask
  // high time allows one cycle of registering
  task automatic run(input logic al, input logic [7:0] hi, input logic [7:0] lo, input cpw_pre_t pre, input int hw, input int per);
    duty(al, hi, lo, pre);
    step(per * 4);
    chk("period", period, per);
    chk("high", high >= hw - 1 && high <= hw + 1, 1);
    $display("test done: duty %0d period %0d", hw, per);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #(50 * 4000);
    errors++;
    complete_run();
  end
  initial
  begin
    step(10);
    i_rst_n = 1;
    chk("counter", o_period_counter, 0);
    chk("oe_n", o_waveform_pin_oe_n, 1);
    i_period_limit = 8'h03;
    i_period_limit_wr = 1;
    i_unit_mode = 4'hc;
    i_unit_enable = 1;
    i_timer_on = 1;
    step(1);
    i_period_limit_wr = 0;
    step(40);
    chk("flag", o_period_match_flag, 1);
    chk("running", o_running, 1);
    i_period_match_flag_clr = 1;
    i_pin_direction = 0;
    step(1);
    i_period_match_flag_clr = 0;
    chk("oe_n", o_waveform_pin_oe_n, 0);
    run(0, 8'h00, 8'h06, PRE_1, 6, 16);
    run(1, 8'h01, 8'h80, PRE_1, 6, 16);
    run(0, 8'h00, 8'h0d, PRE_2, 26, 32);
    run(0, 8'h00, 8'h06, PRE_4, 24, 64);
    i_sleep = 1;
    step(2);
    held = o_period_counter;
    chk("running", o_running, 0);
    step(6);
    chk("frozen", o_period_counter, held);
    i_sleep = 0;
    duty(0, 8'h00, 8'h00, PRE_4);
    step(130);
    repeat (64)
    begin
      step(1);
      chk("pin", o_waveform_pin, 0);
    end
    $display("test done: sleep and zero duty");
    complete_run();
  end
endmodule
`default_nettype wire
